// File: hw/dds_drive.sv
// Drive-side sequencing logic of a dual-headed diskette drive with an APB status port.
//
// Overview of operation
// - Selected drive accepts inputs, drives outputs, lights LED; otherwise idle, except spindle-run, which follows motor-on.
// - Protected diskette asserts protect output and blocks write current unless defeated.
// - Direction low steps inward one track; high steps outward one track.
// - Surface select low uses side 1 head, high uses side 0.
// - Read data valid only from 200 ms after spindle-run asserted.
// - Home-track output low only while heads sit at track 00.
// - With write gate low, each falling write-data edge reverses head current.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
module dds_drive #(
    parameter int TRACK_W    = dds_pkg::TRACK_W,
    parameter int MAX_TRACK  = dds_pkg::MAX_TRACK,
    parameter int SPINUP_CYC = dds_pkg::SPINUP_CYC
) (
    // APB slave
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    // Host interface pins
    input  wire dds_pkg::dds_pins_s pins,
    output logic                  track0_n,
    output logic                  wprot_n,
    output logic                  read_data_n,
    // Mechanism side
    input  wire logic             wp_sensed,
    input  wire logic             read_pulse,
    output logic                  activity_led,
    output logic                  spindle_run,
    output logic                  head_side1,
    output logic                  wr_enable,
    output logic                  wr_current
);
    localparam int CNT_W = $clog2(SPINUP_CYC + 1);
    localparam logic [CNT_W-1:0] SPIN_DONE = CNT_W'(SPINUP_CYC);
    localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

    dds_pkg::dds_pins_s prev_q;
    logic               sel;
    logic               step_rise;
    logic               data_fall;
    logic               wr_ok;
    logic [TRACK_W-1:0] track;
    logic               at_home;

    // Pin state and outputs.
    logic             track0_n_q, track0_n_d;
    logic             wprot_n_q, wprot_n_d;
    logic             rdata_n_q, rdata_n_d;
    logic             led_q, led_d;
    logic             spin_q, spin_d;
    logic             side1_q, side1_d;
    logic             wr_en_q, wr_en_d;
    logic             wr_cur_q, wr_cur_d;
    logic [CNT_W-1:0] spin_cnt_q, spin_cnt_d;
    logic             spin_rdy_q, spin_rdy_d;

    // Register file and bus state.
    logic             wp_defeat_q, wp_defeat_d;
    logic             pready_q, pready_d;
    logic [31:0]      prdata_q, prdata_d;
    logic             pslverr_q, pslverr_d;
    logic [31:0]      status;

    // Pins other than motor-on are only looked at while this unit is selected.
    assign sel       = !pins.unit_sel_n;
    assign step_rise = sel && !prev_q.step_n && pins.step_n;
    assign data_fall = prev_q.write_data_n && !pins.write_data_n;
    // A protected diskette blocks erase and write current unless the control register's defeat bit is set.
    assign wr_ok     = sel && !pins.write_gate_n && !(wp_sensed && !wp_defeat_q);

    dds_head_pos #(
        .TRACK_W   (TRACK_W),
        .MAX_TRACK (MAX_TRACK)
    ) u_head_pos (
        .pclk       (pclk),
        .presetn    (presetn),
        .step_pulse (step_rise),
        .inward     (!pins.dir_in_n),
        .track_q    (track),
        .at_home_q  (at_home)
    );

    always_comb
    begin
        led_d      = sel;
        spin_d     = !pins.motor_on_n;
        side1_d    = sel ? !pins.side_sel_n : side1_q;
        track0_n_d = !(sel && at_home);
        wprot_n_d  = !(sel && wp_sensed);
        wr_en_d    = wr_ok;
        wr_cur_d   = (wr_ok && data_fall) ? !wr_cur_q : wr_cur_q;
        // Spin-up timer restarts whenever the spindle is stopped.
        if (pins.motor_on_n)
            spin_cnt_d = '0;
        else if (spin_cnt_q != SPIN_DONE)
            spin_cnt_d = spin_cnt_q + CNT_ONE;
        else
            spin_cnt_d = spin_cnt_q;
        spin_rdy_d = !pins.motor_on_n && (spin_cnt_d == SPIN_DONE);
        // Read data is muted while writing and before the spindle is up to speed.
        rdata_n_d  = !(sel && spin_rdy_q && pins.write_gate_n && read_pulse);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_q     <= '1;
            led_q      <= 1'b0;
            spin_q     <= 1'b0;
            side1_q    <= 1'b0;
            track0_n_q <= 1'b1;
            wprot_n_q  <= 1'b1;
            wr_en_q    <= 1'b0;
            wr_cur_q   <= 1'b0;
            spin_cnt_q <= '0;
            spin_rdy_q <= 1'b0;
            rdata_n_q  <= 1'b1;
        end
        else
        begin
            prev_q     <= pins;
            led_q      <= led_d;
            spin_q     <= spin_d;
            side1_q    <= side1_d;
            track0_n_q <= track0_n_d;
            wprot_n_q  <= wprot_n_d;
            wr_en_q    <= wr_en_d;
            wr_cur_q   <= wr_cur_d;
            spin_cnt_q <= spin_cnt_d;
            spin_rdy_q <= spin_rdy_d;
            rdata_n_q  <= rdata_n_d;
        end
    end

    always_comb
    begin
        status = '0;
        status[dds_pkg::ST_SEL_BIT]   = sel;
        status[dds_pkg::ST_WP_BIT]    = wp_sensed;
        status[dds_pkg::ST_READY_BIT] = spin_rdy_q;
        status[dds_pkg::ST_HOME_BIT]  = at_home;
        status[dds_pkg::ST_SIDE1_BIT] = side1_q;
        status[dds_pkg::ST_TRACK_LSB +: TRACK_W] = track;
    end

    // One wait state lets every bus output come from a flip-flop.
    always_comb
    begin
        wp_defeat_d = wp_defeat_q;
        pready_d    = psel && penable && !pready_q;
        prdata_d    = prdata_q;
        pslverr_d   = 1'b0;
        if (psel && penable && !pready_q)
        begin
            prdata_d = '0;
            case (paddr)
                dds_pkg::CTRL_OFF:
                begin
                    if (pwrite)
                        wp_defeat_d = pwdata[dds_pkg::CTRL_WPDEF_BIT];
                    else
                        prdata_d[dds_pkg::CTRL_WPDEF_BIT] = wp_defeat_q;
                end
                dds_pkg::STATUS_OFF:
                begin
                    if (!pwrite)
                        prdata_d = status;
                end
                default:
                    pslverr_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wp_defeat_q <= dds_pkg::CTRL_RESET[dds_pkg::CTRL_WPDEF_BIT];
            pready_q    <= 1'b0;
            prdata_q    <= '0;
            pslverr_q   <= 1'b0;
        end
        else
        begin
            wp_defeat_q <= wp_defeat_d;
            pready_q    <= pready_d;
            prdata_q    <= prdata_d;
            pslverr_q   <= pslverr_d;
        end
    end

    assign pready       = pready_q;
    assign prdata       = prdata_q;
    assign pslverr      = pslverr_q;
    assign track0_n     = track0_n_q;
    assign wprot_n      = wprot_n_q;
    assign read_data_n  = rdata_n_q;
    assign activity_led = led_q;
    assign spindle_run  = spin_q;
    assign head_side1   = side1_q;
    assign wr_enable    = wr_en_q;
    assign wr_current   = wr_cur_q;

    property p_deselect_idle;
        @(posedge pclk) disable iff (!presetn)
        pins.unit_sel_n |=> (!led_q && track0_n_q && wprot_n_q && rdata_n_q && !wr_en_q);
    endproperty
    a_deselect_idle: assert property (p_deselect_idle) else $error("deselected drive left an output active");

    property p_protect_block;
        @(posedge pclk) disable iff (!presetn)
        (sel && wp_sensed && !wp_defeat_q) |=> (!wr_en_q && !wprot_n_q && wr_cur_q == $past(wr_cur_q));
    endproperty
    a_protect_block: assert property (p_protect_block) else $error("write current on a protected diskette");

    property p_step_in;
        @(posedge pclk) disable iff (!presetn)
        (step_rise && !pins.dir_in_n && track != TRACK_W'(MAX_TRACK)) |=> (track == $past(track) + TRACK_W'(1));
    endproperty
    a_step_in: assert property (p_step_in) else $error("inward step did not advance one track");

    property p_step_out;
        @(posedge pclk) disable iff (!presetn)
        (step_rise && pins.dir_in_n && track != '0) |=> (track == $past(track) - TRACK_W'(1));
    endproperty
    a_step_out: assert property (p_step_out) else $error("outward step did not retreat one track");

    property p_side_head;
        @(posedge pclk) disable iff (!presetn)
        sel |=> (side1_q == !$past(pins.side_sel_n));
    endproperty
    a_side_head: assert property (p_side_head) else $error("wrong head for surface select");

    property p_spinup_mute;
        @(posedge pclk) disable iff (!presetn)
        pins.motor_on_n |=> !spin_rdy_q ##1 rdata_n_q;
    endproperty
    a_spinup_mute: assert property (p_spinup_mute) else $error("read data passed before spin-up");

    property p_home_flag;
        @(posedge pclk) disable iff (!presetn)
        sel |=> (track0_n_q == !($past(at_home) && $past(track) == '0));
    endproperty
    a_home_flag: assert property (p_home_flag) else $error("home output disagrees with head position");

    property p_flux_reverse;
        @(posedge pclk) disable iff (!presetn)
        (wr_ok && data_fall) |=> (wr_cur_q != $past(wr_cur_q)) && wr_en_q;
    endproperty
    a_flux_reverse: assert property (p_flux_reverse) else $error("write current not reversed on data edge");
endmodule // dds_drive

// File: shared/dds_pkg.sv
// Shared constants, register map and pin bundle for the diskette drive sequencing block.
package dds_pkg;
    // Register byte offsets on APB.
    localparam logic [11:0] CTRL_OFF   = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    // Control register fields.
    localparam int          CTRL_WPDEF_BIT = 0;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    // Status register field positions.
    localparam int ST_SEL_BIT   = 0;
    localparam int ST_WP_BIT    = 1;
    localparam int ST_READY_BIT = 2;
    localparam int ST_HOME_BIT  = 3;
    localparam int ST_SIDE1_BIT = 4;
    localparam int ST_TRACK_LSB = 8;
    // Head positioning defaults.
    localparam int TRACK_W   = 7;
    localparam int MAX_TRACK = 79;
    // Read data is held back until the spindle has run this long.
    localparam int CLK_HZ     = 20_000_000;
    localparam int SPINUP_MS  = 200;
    localparam int SPINUP_CYC = SPINUP_MS * (CLK_HZ / 1000);

    // Host-driven interface pins, all active low.
    typedef struct packed {
        logic unit_sel_n;
        logic motor_on_n;
        logic dir_in_n;
        logic step_n;
        logic write_gate_n;
        logic write_data_n;
        logic side_sel_n;
    } dds_pins_s;
endpackage

// File: hw/dds_head_pos.sv
// Head position tracker: counts tracks on each step and flags the home track.
`timescale 1ns/10ps
module dds_head_pos #(
    parameter int TRACK_W   = dds_pkg::TRACK_W,
    parameter int MAX_TRACK = dds_pkg::MAX_TRACK
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Step request
    input  wire logic               step_pulse,
    input  wire logic               inward,
    // Position
    output logic [TRACK_W-1:0]      track_q,
    output logic                    at_home_q
);
    localparam logic [TRACK_W-1:0] TOP  = TRACK_W'(MAX_TRACK);
    localparam logic [TRACK_W-1:0] ZERO = '0;
    localparam logic [TRACK_W-1:0] ONE  = TRACK_W'(1);

    logic [TRACK_W-1:0] track_d;
    logic               at_home_d;

    // The carriage stops at its end positions; further steps are absorbed.
    always_comb
    begin
        track_d = track_q;
        if (step_pulse)
        begin
            if (inward && track_q != TOP)
                track_d = track_q + ONE;
            else if (!inward && track_q != ZERO)
                track_d = track_q - ONE;
        end
        at_home_d = (track_d == ZERO);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            track_q   <= '0;
            at_home_q <= 1'b1;
        end
        else
        begin
            track_q   <= track_d;
            at_home_q <= at_home_d;
        end
    end
endmodule // dds_head_pos

// File: test/dds_host_model.sv
// Host controller model that drives the drive's select, motor, step, gate, side and data lines.
`timescale 1ns/10ps
module dds_host_model #(
    // Gaps are far shorter than a real host's; the drive does not police host timing.
    parameter int DIR_SETUP_CYC = 20,
    parameter int STEP_LOW_CYC  = 20,
    parameter int STEP_GAP_CYC  = 40,
    parameter int REV_GAP_CYC   = 80,
    parameter int SETTLE_CYC    = 4
) (
    // Clock
    input  wire logic          pclk,
    // Drive status
    input  wire logic          track0_n,
    // Host lines toward the drive
    output dds_pkg::dds_pins_s pins
);
    logic last_inward;

    initial
    begin
        pins        = 7'h7f;
        last_inward = 1'b0;
    end

    // A single select line exists here, so no second drive is ever enabled.
    // Callers change lines in the read and write order the drive expects.
    // Each change is followed by the settle time that covers gate and side changes.
    task automatic set_lines(input logic sel_n, input logic motor_n, input logic gate_n, input logic side_n);
        @(posedge pclk);
        pins.unit_sel_n   <= sel_n;
        pins.motor_on_n   <= motor_n;
        pins.write_gate_n <= gate_n;
        pins.side_sel_n   <= side_n;
        repeat (SETTLE_CYC) @(posedge pclk);
    endtask

    // One pulse per track; the gap before it depends on a direction change.
    task automatic step(input logic inward);
        repeat (inward == last_inward ? STEP_GAP_CYC : REV_GAP_CYC) @(posedge pclk);
        pins.dir_in_n <= ~inward;
        repeat (DIR_SETUP_CYC) @(posedge pclk);
        pins.step_n <= 1'b0;
        repeat (STEP_LOW_CYC) @(posedge pclk);
        pins.step_n <= 1'b1;
        last_inward = inward;
    endtask

    // The bound stops a drive whose home line never answers from hanging the run.
    task automatic home();
        for (int i = 0; i < 100 && track0_n !== 1'b0; i++)
        begin
            step(1'b0);
            repeat (3) @(posedge pclk);
        end
    endtask

    // Bit clock recovery and the retry policy live in controller firmware above this model.
    // One unshifted flux transition is sent, so no precompensation is applied.
    task automatic data_edge();
        @(posedge pclk);
        pins.write_data_n <= 1'b0;
        repeat (2) @(posedge pclk);
        pins.write_data_n <= 1'b1;
    endtask
endmodule // dds_host_model

// File: test/dds_drive_tb_top.sv
// Self-checking testbench for the diskette drive sequencing block.
`timescale 1ns/10ps
module dds_drive_tb_top;
    logic               pclk;
    logic               presetn;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata;
    logic               pready;
    logic [31:0]        prdata;
    logic               pslverr;
    dds_pkg::dds_pins_s pins;
    logic               track0_n;
    logic               wprot_n;
    logic               read_data_n;
    logic               wp_sensed;
    logic               read_pulse;
    logic               activity_led;
    logic               spindle_run;
    logic               head_side1;
    logic               wr_enable;
    logic               wr_current;
    logic [31:0]        rd;
    logic               er;
    int                 n_fail;
    int                 samples_checked;
    // Row: sel_n, motor_n, gate_n, side_n, wp, defeat, then led, wprot_n, side1, wr_enable, spindle.
    logic [10:0]        rows [6] = '{11'h11d, 11'h09b, 11'h0d1, 11'h077, 11'h6cc, 11'h398};

    dds_drive #(.SPINUP_CYC(20)) u_dds_drive (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .pins(pins), .track0_n(track0_n), .wprot_n(wprot_n), .read_data_n(read_data_n), .wp_sensed(wp_sensed),
        .read_pulse(read_pulse), .activity_led(activity_led), .spindle_run(spindle_run),
        .head_side1(head_side1), .wr_enable(wr_enable), .wr_current(wr_current));

    dds_host_model u_dds_host_model (.pclk(pclk), .track0_n(track0_n), .pins(pins));

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic print_verdict();
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
        begin
            n_fail++;
            print_verdict();
        end
    endtask

    initial
    begin
        n_fail = 0;
        samples_checked = 0;
        {presetn, psel, penable, pwrite, wp_sensed, read_pulse} = 6'h00;
        paddr  = 12'h000;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        chk({track0_n, wprot_n, read_data_n, activity_led, wr_enable, pready}, 32'h38);
        presetn <= 1'b1;
        apb(1'b0, dds_pkg::CTRL_OFF, 32'h0);
        chk(rd, dds_pkg::CTRL_RESET);
        foreach (rows[i])
        begin
            apb(1'b1, dds_pkg::CTRL_OFF, {31'h0, rows[i][5]});
            wp_sensed <= rows[i][6];
            u_dds_host_model.set_lines(rows[i][10], rows[i][9], rows[i][8], rows[i][7]);
            rd = {27'h0, activity_led, wprot_n, head_side1, wr_enable, spindle_run};
            chk(rd, {27'h0, rows[i][4:0]});
        end
        apb(1'b1, dds_pkg::CTRL_OFF, 32'h0);
        wp_sensed <= 1'b0;
        u_dds_host_model.set_lines(1'b0, 1'b0, 1'b0, 1'b1);
        u_dds_host_model.data_edge();
        repeat (3) @(posedge pclk);
        chk(wr_current, 32'h1);
        wp_sensed <= 1'b1;
        repeat (3) @(posedge pclk);
        u_dds_host_model.data_edge();
        repeat (3) @(posedge pclk);
        chk({wr_enable, wr_current}, 32'h1);
        wp_sensed <= 1'b0;
        read_pulse <= 1'b1;
        u_dds_host_model.set_lines(1'b0, 1'b1, 1'b1, 1'b1);
        u_dds_host_model.set_lines(1'b0, 1'b0, 1'b1, 1'b1);
        chk(read_data_n, 32'h1);
        repeat (25) @(posedge pclk);
        chk(read_data_n, 32'h0);
        read_pulse <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(read_data_n, 32'h1);
        chk(track0_n, 32'h0);
        repeat (3) u_dds_host_model.step(1'b1);
        repeat (3) @(posedge pclk);
        apb(1'b0, dds_pkg::STATUS_OFF, 32'h0);
        chk(rd[dds_pkg::ST_TRACK_LSB +: dds_pkg::TRACK_W], 32'h3);
        chk({track0_n, rd[dds_pkg::ST_HOME_BIT]}, 32'h2);
        chk(rd[dds_pkg::ST_SEL_BIT], 32'h1);
        chk(rd[dds_pkg::ST_READY_BIT], 32'h1);
        chk({rd[dds_pkg::ST_WP_BIT], rd[dds_pkg::ST_SIDE1_BIT]}, 32'h0);
        u_dds_host_model.step(1'b0);
        repeat (3) @(posedge pclk);
        apb(1'b0, dds_pkg::STATUS_OFF, 32'h0);
        chk(rd[dds_pkg::ST_TRACK_LSB +: dds_pkg::TRACK_W], 32'h2);
        u_dds_host_model.home();
        u_dds_host_model.step(1'b0);
        repeat (3) @(posedge pclk);
        apb(1'b0, dds_pkg::STATUS_OFF, 32'h0);
        chk({track0_n, rd[dds_pkg::ST_HOME_BIT], rd[dds_pkg::ST_TRACK_LSB +: dds_pkg::TRACK_W]}, 32'h80);
        apb(1'b1, 12'h008, 32'h1);
        chk(er, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, dds_pkg::STATUS_OFF, 32'h0);
        chk(er, 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({track0_n, activity_led, spindle_run, pready}, 32'h8);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk({track0_n, activity_led, spindle_run}, 32'h3);
        apb(1'b0, dds_pkg::STATUS_OFF, 32'h0);
        chk(rd[dds_pkg::ST_TRACK_LSB +: dds_pkg::TRACK_W], 32'h0);
        print_verdict();
    end
endmodule // dds_drive_tb_top
